// ==== mcuic_pkg.sv ====
// shared constants for the microcontroller interrupt controller
package mcuic_pkg;
   // byte offsets on the register bus
   localparam logic [7:0] ADR_CTRL = 8'h00; // irq_control_reg
   localparam logic [7:0] ADR_PFA  = 8'h04; // periph_flags_a
   localparam logic [7:0] ADR_PFB  = 8'h08; // periph_flags_b
   localparam logic [7:0] ADR_PEA  = 8'h0C; // periph_enables_a
   localparam logic [7:0] ADR_PEB  = 8'h10; // periph_enables_b
   localparam logic [7:0] ADR_OPT  = 8'h14; // option, edge select
   localparam logic [7:0] ADR_STAT = 8'h18; // core-facing state
   // irq_control_reg bit positions
   localparam int B_GIE  = 7; // global_irq_enable
   localparam int B_PGE  = 6; // periph_group_enable
   localparam int B_TIE  = 5; // timer8_ovf_enable
   localparam int B_EIE  = 4; // ext_irq_enable
   localparam int B_PCE  = 3; // port_change_enable
   localparam int B_TIF  = 2; // timer8_ovf_flag
   localparam int B_EIF  = 1; // ext_irq_flag
   localparam int B_PCF  = 0; // port_change_flag
   localparam int B_EDGE = 6; // ext_edge_select in option
   // reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_OPT  = 8'hFF;
   localparam logic [7:0] RST_PER  = 8'h00;
   // vector and instruction timing
   localparam logic [12:0] VECTOR_ADDR = 13'h0004;
   localparam logic [1:0]  Q_LAST      = 2'h3; // four clocks per instr
   localparam logic [7:0]  TMR_MAX     = 8'hFF;
   // sleep state machine
   typedef enum logic [1:0] {
      ST_RUN   = 2'b01,
      ST_SLEEP = 2'b10
   } mcuic_state_e;
endpackage : mcuic_pkg

// ==== mcuic_top.sv ====
// interrupt controller: flags, enables, vectoring, sleep wake-up
`timescale 1ns/100ps
`default_nettype none
module mcuic_top (
   input  wire logic        clk_i,          // core clock
   input  wire logic        rst_i,          // sync reset, high
   input  wire logic        wb_cyc_i,       // wishbone cycle
   input  wire logic        wb_stb_i,       // wishbone strobe
   input  wire logic        wb_we_i,        // wishbone write
   input  wire logic [7:0]  wb_adr_i,       // byte address
   input  wire logic [3:0]  wb_sel_i,       // byte lanes
   input  wire logic [31:0] wb_dat_i,       // write data
   output logic      [31:0] wb_dat_o,       // read data
   output logic             wb_ack_o,       // acknowledge
   input  wire logic        ext_irq_pin_i,  // external edge pin
   input  wire logic [7:4]  port_b_pins_i,  // upper port nibble
   input  wire logic [7:0]  timer8_count_i, // timer value, same clock
   input  wire logic [7:0]  periph_evt_a_i, // peripheral events a
   input  wire logic        periph_evt_b_i, // peripheral event b
   input  wire logic        irq_accept_i,   // core takes vector
   input  wire logic        return_from_irq_instr_i, // return executed
   input  wire logic        sleep_instr_i,  // sleep executed
   output logic             vector_req_o,   // vector request
   output logic             push_ret_pc_o,  // push return pc only
   output logic             pc_load_o,      // load pc with vector
   output logic      [12:0] vector_addr_o,  // vector address
   output logic             sleeping_o,     // core halted
   output logic             wake_o          // wake pulse
);
   // all state of the block
   typedef struct packed {
      logic [7:0]   ctrl;
      logic [7:0]   pfa;
      logic         pfb;
      logic [7:0]   pea;
      logic         peb;
      logic [7:0]   opt;
      logic [1:0]   ext_sy;
      logic         ext_prev;
      logic [7:0]   port_sy;
      logic [3:0]   port_prev;
      logic [7:0]   tmr_prev;
      logic [1:0]   qph;
      logic         req;
      logic         push;
      logic         load;
      logic         wake;
      logic         wake_vec;
      logic         ack;
      logic [31:0]  rdata;
      mcuic_pkg::mcuic_state_e st;
   } mcuic_s;

   mcuic_s cur;
   mcuic_s next_s;

   // byte-lane merge of a write into an 8-bit register
   function automatic logic [7:0] lane0(input logic [7:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] sel);
      lane0 = sel[0] ? d[7:0] : old;
   endfunction : lane0

   logic       bus_req;
   logic       wr;
   logic       ext_rise;
   logic       ext_fall;
   logic       ext_evt;
   logic       port_evt;
   logic       tmr_evt;
   logic       core_pend;
   logic       per_pend;
   logic       any_en;
   logic       pend;

   // bus qualifiers
   assign bus_req = wb_cyc_i && wb_stb_i && !cur.ack;
   assign wr      = bus_req && wb_we_i;

   // events from synchronised pins and timer
   assign ext_rise = cur.ext_sy[1] && !cur.ext_prev;
   assign ext_fall = !cur.ext_sy[1] && cur.ext_prev;
   assign ext_evt  = cur.opt[mcuic_pkg::B_EDGE] ? ext_rise : ext_fall;
   assign port_evt = cur.port_sy[7:4] != cur.port_prev;
   assign tmr_evt  = (cur.tmr_prev == mcuic_pkg::TMR_MAX) &&
                     (timer8_count_i == 8'h00);

   // masked requests: core group and peripheral group
   assign core_pend = (cur.ctrl[mcuic_pkg::B_TIF] && cur.ctrl[mcuic_pkg::B_TIE]) ||
                      (cur.ctrl[mcuic_pkg::B_EIF] && cur.ctrl[mcuic_pkg::B_EIE]) ||
                      (cur.ctrl[mcuic_pkg::B_PCF] && cur.ctrl[mcuic_pkg::B_PCE]);
   assign per_pend  = cur.ctrl[mcuic_pkg::B_PGE] &&
                      (|(cur.pfa & cur.pea) || (cur.pfb && cur.peb));
   // wake needs only the individual enable, not the group or global
   assign any_en    = core_pend || |(cur.pfa & cur.pea) || (cur.pfb && cur.peb);
   assign pend      = cur.ctrl[mcuic_pkg::B_GIE] && (core_pend || per_pend);

   // next-state logic
   always_comb begin
      next_s = cur;
      // pin synchronisers, two flops before use
      next_s.ext_sy   = {cur.ext_sy[0], ext_irq_pin_i};
      next_s.ext_prev = cur.ext_sy[1];
      next_s.port_sy  = {cur.port_sy[3:0], port_b_pins_i};
      next_s.port_prev = cur.port_sy[7:4];
      next_s.tmr_prev = timer8_count_i;
      next_s.qph      = cur.qph + 2'h1;
      next_s.push     = 1'b0;
      next_s.load     = 1'b0;
      next_s.wake     = 1'b0;

      // bus: one-cycle registered acknowledge, unmapped reads zero
      next_s.ack   = bus_req;
      next_s.rdata = 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
         case (wb_adr_i)
            mcuic_pkg::ADR_CTRL: next_s.rdata = {24'h000000, cur.ctrl};
            mcuic_pkg::ADR_PFA:  next_s.rdata = {24'h000000, cur.pfa};
            mcuic_pkg::ADR_PFB:  next_s.rdata = {31'h00000000, cur.pfb};
            mcuic_pkg::ADR_PEA:  next_s.rdata = {24'h000000, cur.pea};
            mcuic_pkg::ADR_PEB:  next_s.rdata = {31'h00000000, cur.peb};
            mcuic_pkg::ADR_OPT:  next_s.rdata = {24'h000000, cur.opt};
            mcuic_pkg::ADR_STAT: next_s.rdata = {28'h0000000, cur.wake_vec,
                                   cur.st == mcuic_pkg::ST_SLEEP, cur.req, pend};
            default:             next_s.rdata = 32'h0000_0000;
         endcase
      end
      // software writes; flags may be cleared by writing zero
      if (wr) begin
         case (wb_adr_i)
            mcuic_pkg::ADR_CTRL: next_s.ctrl = lane0(cur.ctrl, wb_dat_i, wb_sel_i);
            mcuic_pkg::ADR_PFA:  next_s.pfa  = lane0(cur.pfa, wb_dat_i, wb_sel_i);
            mcuic_pkg::ADR_PFB:  next_s.pfb  = wb_sel_i[0] ? wb_dat_i[0] : cur.pfb;
            mcuic_pkg::ADR_PEA:  next_s.pea  = lane0(cur.pea, wb_dat_i, wb_sel_i);
            mcuic_pkg::ADR_PEB:  next_s.peb  = wb_sel_i[0] ? wb_dat_i[0] : cur.peb;
            mcuic_pkg::ADR_OPT:  next_s.opt  = lane0(cur.opt, wb_dat_i, wb_sel_i);
            default: ;
         endcase
      end
      // hardware events set flags whatever the enables; set beats clear
      next_s.ctrl[mcuic_pkg::B_EIF] = next_s.ctrl[mcuic_pkg::B_EIF] | ext_evt;
      next_s.ctrl[mcuic_pkg::B_TIF] = next_s.ctrl[mcuic_pkg::B_TIF] | tmr_evt;
      next_s.ctrl[mcuic_pkg::B_PCF] = next_s.ctrl[mcuic_pkg::B_PCF] | port_evt;
      next_s.pfa = next_s.pfa | periph_evt_a_i;
      next_s.pfb = next_s.pfb | periph_evt_b_i;

      // request sampled at the instruction boundary
      if (cur.qph == mcuic_pkg::Q_LAST) begin
         next_s.req = pend && (cur.st == mcuic_pkg::ST_RUN);
      end
      // return re-enables; accept wins since it follows in program order
      if (return_from_irq_instr_i) begin
         next_s.ctrl[mcuic_pkg::B_GIE] = 1'b1;
      end
      if (irq_accept_i && cur.req) begin
         next_s.ctrl[mcuic_pkg::B_GIE] = 1'b0;
         next_s.req  = 1'b0;
         next_s.push = 1'b1;
         next_s.load = 1'b1;
      end

      // sleep and wake-up
      case (cur.st)
         mcuic_pkg::ST_RUN: begin
            // an individually enabled flag already set (any_en) turns sleep into a no-op
            if (sleep_instr_i && !any_en) begin
               next_s.st = mcuic_pkg::ST_SLEEP;
            end
            if (cur.wake_vec && cur.qph == mcuic_pkg::Q_LAST) begin
               next_s.wake_vec = 1'b0;
               next_s.req      = 1'b1;
            end
         end
         mcuic_pkg::ST_SLEEP: begin
            if (any_en) begin
               next_s.st       = mcuic_pkg::ST_RUN;
               next_s.wake     = 1'b1;
               next_s.wake_vec = cur.ctrl[mcuic_pkg::B_GIE];
            end
         end
         default: next_s.st = mcuic_pkg::ST_RUN;
      endcase
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur       <= '0;
         cur.ctrl  <= mcuic_pkg::RST_CTRL;
         cur.opt   <= mcuic_pkg::RST_OPT;
         cur.pfa   <= mcuic_pkg::RST_PER;
         cur.pea   <= mcuic_pkg::RST_PER;
         cur.st    <= mcuic_pkg::ST_RUN;
      end else begin
         cur <= next_s;
      end
   end

   // outputs
   assign wb_dat_o      = cur.rdata;
   assign wb_ack_o      = cur.ack;
   assign vector_req_o  = cur.req;
   assign push_ret_pc_o = cur.push;
   assign pc_load_o     = cur.load;
   assign vector_addr_o = mcuic_pkg::VECTOR_ADDR;
   assign sleeping_o    = cur.st == mcuic_pkg::ST_SLEEP;
   assign wake_o        = cur.wake;

   // checks
   property p_gie_reset;
      @(posedge clk_i) $past(rst_i) |-> !cur.ctrl[mcuic_pkg::B_GIE];
   endproperty
   a_gie_reset: assert property (p_gie_reset) else $error("gie not cleared");

   property p_no_req_gie_off;
      @(posedge clk_i) disable iff (rst_i)
      (!cur.ctrl[mcuic_pkg::B_GIE] && !cur.wake_vec && !cur.req)
         |=> !cur.req || $past(pend);
   endproperty
   a_no_req_gie_off: assert property (p_no_req_gie_off) else $error("req w/o gie");

   property p_req_soon;
      @(posedge clk_i) disable iff (rst_i)
      (pend && cur.st == mcuic_pkg::ST_RUN && !irq_accept_i)[*4] |=> cur.req;
   endproperty
   a_req_soon: assert property (p_req_soon) else $error("request late");

   property p_accept;
      @(posedge clk_i) disable iff (rst_i)
      (irq_accept_i && cur.req) |=> pc_load_o && push_ret_pc_o &&
         !cur.ctrl[mcuic_pkg::B_GIE];
   endproperty
   a_accept: assert property (p_accept) else $error("accept not handled");

   property p_return;
      @(posedge clk_i) disable iff (rst_i)
      (return_from_irq_instr_i && !(irq_accept_i && cur.req)) |=>
         cur.ctrl[mcuic_pkg::B_GIE];
   endproperty
   a_return: assert property (p_return) else $error("gie not set");

   property p_ext_flag;
      @(posedge clk_i) disable iff (rst_i)
      $rose(ext_irq_pin_i) && cur.opt[mcuic_pkg::B_EDGE] && !wr
         ##3 !wr |=> cur.ctrl[mcuic_pkg::B_EIF];
   endproperty
   a_ext_flag: assert property (p_ext_flag) else $error("edge missed");

   property p_tmr_flag;
      @(posedge clk_i) disable iff (rst_i)
      tmr_evt |=> cur.ctrl[mcuic_pkg::B_TIF];
   endproperty
   a_tmr_flag: assert property (p_tmr_flag) else $error("ovf missed");

   property p_per_flag;
      @(posedge clk_i) disable iff (rst_i)
      periph_evt_a_i[0] |=> cur.pfa[0];
   endproperty
   a_per_flag: assert property (p_per_flag) else $error("flag lost");

   property p_wake;
      @(posedge clk_i) disable iff (rst_i)
      (cur.st == mcuic_pkg::ST_SLEEP && any_en) |=> wake_o && !sleeping_o &&
         (cur.wake_vec == $past(cur.ctrl[mcuic_pkg::B_GIE]));
   endproperty
   a_wake: assert property (p_wake) else $error("wake wrong");

   property p_ack_one;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack too long");

   c_vector: cover property (@(posedge clk_i) irq_accept_i && cur.req);
   c_wake_vec: cover property (@(posedge clk_i) wake_o ##[1:8] cur.req);
   c_wake_plain: cover property (@(posedge clk_i) wake_o && !cur.ctrl[mcuic_pkg::B_GIE]);
endmodule : mcuic_top
`default_nettype wire

// ==== mcuic_core_model.sv ====
// core-side partner: takes vectors and tracks the program counter
`timescale 1ns/100ps
`default_nettype none
module mcuic_core_model (
   input  wire logic        clk_i,         // core clock
   input  wire logic        rst_i,         // sync reset, high
   input  wire logic [3:0]  lat_i,         // wait before accept
   input  wire logic        vector_req_i,  // vector request
   input  wire logic        pc_load_i,     // load pc strobe
   input  wire logic        push_ret_i,    // push return pc
   input  wire logic [12:0] vector_addr_i, // vector address
   output logic             irq_accept_o,  // accept pulse
   output logic      [7:0]  n_load_o,      // vector entries seen
   output logic      [12:0] pc_o           // program counter
);
   logic [3:0] wait_cnt;
   // accept after a delay; enter vector only with push and load together
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_accept_o <= 1'b0;
         n_load_o     <= 8'h00;
         pc_o         <= 13'h0000;
         wait_cnt     <= 4'h0;
      end else begin
         irq_accept_o <= 1'b0;
         if (pc_load_i && push_ret_i) begin
            n_load_o <= n_load_o + 8'h01;
            pc_o     <= vector_addr_i;
         end
         if (vector_req_i && !irq_accept_o) begin
            if (wait_cnt >= lat_i) begin
               irq_accept_o <= 1'b1;
               wait_cnt     <= 4'h0;
            end else begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end else begin
            wait_cnt <= 4'h0;
         end
      end
   end
endmodule : mcuic_core_model
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic        ext_irq_pin_i, periph_evt_b_i, irq_accept_i, sleep_instr_i;
   logic        return_from_irq_instr_i, vector_req_o, push_ret_pc_o;
   logic        pc_load_o, sleeping_o, wake_o;
   logic [3:0]  wb_sel_i, lat;
   logic [7:4]  port_b_pins_i;
   logic [7:0]  wb_adr_i, timer8_count_i, periph_evt_a_i, n_load;
   logic [12:0] vector_addr_o, pc;
   logic [31:0] wb_dat_i, wb_dat_o, rdat;
   int          error_cnt, n_tests;
   // device under test and core partner
   mcuic_top i_dut (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_irq_pin_i, .port_b_pins_i,
      .timer8_count_i, .periph_evt_a_i, .periph_evt_b_i, .irq_accept_i,
      .return_from_irq_instr_i, .sleep_instr_i, .vector_req_o, .push_ret_pc_o,
      .pc_load_o, .vector_addr_o, .sleeping_o, .wake_o);
   mcuic_core_model i_core (
      .clk_i, .rst_i, .lat_i(lat), .vector_req_i(vector_req_o), .pc_load_i(pc_load_o),
      .push_ret_i(push_ret_pc_o), .vector_addr_i(vector_addr_o),
      .irq_accept_o(irq_accept_i), .n_load_o(n_load), .pc_o(pc));
   // clock
   always #5 clk_i = ~clk_i;
   task automatic complete_run();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run
   // one classic bus cycle, held until ack
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // sample ack and data at the rising edge, release only after it
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 20) begin
         error_cnt++;
         complete_run();
      end
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(rdat, e)
   endtask : rd
   function automatic logic pick(input int k);
      pick = (k == 0) ? vector_req_o : (k == 1) ? sleeping_o : wake_o;
   endfunction : pick
   // bounded wait for a core-side output
   task automatic wait_for(input int k, input logic v, input int lim);
      int n;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (pick(k) !== v && n < lim);
      `CHK(pick(k), v)
      if (pick(k) !== v) begin
         complete_run();
      end
   endtask : wait_for
   task automatic hold_off(input int k, input int c);
      repeat (c) begin
         @(negedge clk_i);
         `CHK(pick(k), 1'b0)
      end
   endtask : hold_off
   // drive pin and instruction strobes
   task automatic drive(input logic pin, input logic slp, input logic ret);
      @(posedge clk_i);
      ext_irq_pin_i           <= pin;
      sleep_instr_i           <= slp;
      return_from_irq_instr_i <= ret;
      @(posedge clk_i);
      sleep_instr_i           <= 1'b0;
      return_from_irq_instr_i <= 1'b0;
   endtask : drive
   task automatic entry(input logic [7:0] cnt);
      wait_for(0, 1'b0, 20);
      repeat (2) @(negedge clk_i);
      `CHK(n_load, cnt)
      `CHK(pc, 13'h0004)
   endtask : entry
   task automatic s_reset();
      rd(mcuic_pkg::ADR_CTRL, 32'h0);
      rd(mcuic_pkg::ADR_OPT, 32'hFF);
      rd(mcuic_pkg::ADR_PEB, 32'h0);
      wr(8'h1C, 32'hFF);
      rd(8'h1C, 32'h0);
   endtask : s_reset
   // every source flags with all enables off
   task automatic s_flags();
      @(posedge clk_i);
      timer8_count_i <= 8'hFF;
      ext_irq_pin_i  <= 1'b1;
      port_b_pins_i  <= 4'h5;
      periph_evt_a_i <= 8'hA5;
      periph_evt_b_i <= 1'b1;
      @(posedge clk_i);
      timer8_count_i <= 8'h00;
      periph_evt_a_i <= 8'h00;
      periph_evt_b_i <= 1'b0;
      hold_off(0, 8);
      rd(mcuic_pkg::ADR_CTRL, 32'h07);
      rd(mcuic_pkg::ADR_PFA, 32'hA5);
      rd(mcuic_pkg::ADR_PFB, 32'h01);
      wr(mcuic_pkg::ADR_CTRL, 32'h0);
      wr(mcuic_pkg::ADR_PFA, 32'h0);
      wr(mcuic_pkg::ADR_PFB, 32'h0);
      wr(mcuic_pkg::ADR_OPT, 32'hBF);
      drive(1'b0, 1'b0, 1'b0);
      repeat (4) @(posedge clk_i);
      rd(mcuic_pkg::ADR_CTRL, 32'h02);
      wr(mcuic_pkg::ADR_CTRL, 32'h0);
      drive(1'b1, 1'b0, 1'b0);
      repeat (4) @(posedge clk_i);
      rd(mcuic_pkg::ADR_CTRL, 32'h0);
      wr(mcuic_pkg::ADR_OPT, 32'hFF);
   endtask : s_flags
   // peripheral gating, entry and return
   task automatic s_periph();
      wr(mcuic_pkg::ADR_PEA, 32'h01);
      wr(mcuic_pkg::ADR_CTRL, 32'h80);
      @(posedge clk_i);
      periph_evt_a_i <= 8'h01;
      @(posedge clk_i);
      periph_evt_a_i <= 8'h00;
      hold_off(0, 12);
      wr(mcuic_pkg::ADR_CTRL, 32'hC0);
      wait_for(0, 1'b1, 8);
      entry(8'h01);
      rd(mcuic_pkg::ADR_CTRL, 32'h40);
      wr(mcuic_pkg::ADR_PFA, 32'h0);
      drive(1'b1, 1'b0, 1'b1);
      rd(mcuic_pkg::ADR_CTRL, 32'hC0);
      hold_off(0, 8);
      wr(mcuic_pkg::ADR_CTRL, 32'h90);
      lat <= 4'h0;
      drive(1'b0, 1'b0, 1'b0);
      hold_off(0, 6);
      drive(1'b1, 1'b0, 1'b0);
      wait_for(0, 1'b1, 14);
      entry(8'h02);
      rd(mcuic_pkg::ADR_CTRL, 32'h12);
   endtask : s_periph
   // wake with global enable clear, then set
   task automatic s_sleep();
      wr(mcuic_pkg::ADR_CTRL, 32'h10);
      drive(1'b0, 1'b1, 1'b0);
      wait_for(1, 1'b1, 4);
      rd(mcuic_pkg::ADR_STAT, 32'h04);
      drive(1'b1, 1'b0, 1'b0);
      wait_for(2, 1'b1, 12);
      `CHK(sleeping_o, 1'b0)
      hold_off(0, 12);
      wr(mcuic_pkg::ADR_CTRL, 32'h90);
      drive(1'b0, 1'b1, 1'b0);
      wait_for(1, 1'b1, 4);
      drive(1'b1, 1'b0, 1'b0);
      wait_for(2, 1'b1, 12);
      wait_for(0, 1'b1, 8);
      entry(8'h03);
   endtask : s_sleep
   // reset in mid-run clears a set global enable and restores the option to FF
   task automatic s_rereset();
      wr(mcuic_pkg::ADR_CTRL, 32'h80);
      wr(mcuic_pkg::ADR_OPT, 32'hBF);
      rd(mcuic_pkg::ADR_CTRL, 32'h80);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(mcuic_pkg::ADR_CTRL, 32'h0);
      rd(mcuic_pkg::ADR_OPT, 32'hFF);
   endtask : s_rereset
   initial begin
      {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, ext_irq_pin_i, periph_evt_b_i} = 6'h00;
      {sleep_instr_i, return_from_irq_instr_i} = 2'h0;
      {wb_adr_i, timer8_count_i, periph_evt_a_i, port_b_pins_i} = 28'h0;
      wb_dat_i  = 32'h0;
      wb_sel_i  = 4'hF;
      lat       = 4'h3;
      rst_i     = 1'b1;
      error_cnt = 0;
      n_tests   = 0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      s_reset();
      s_flags();
      s_periph();
      s_sleep();
      s_rereset();
      complete_run();
   end
endmodule : testbench
`default_nettype wire
